// File: bench/sbc_spi_frame_checker.sv
// Port checker for the SPI command frame block
`timescale 1ns/100ps
`default_nettype none

module sbc_spi_frame_checker
    import sbc_spi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic parity_en,
    input wire logic [7:0] status_fixed,
    input wire logic [7:0] status_ext,
    input wire sbc_flag_set_t flag_set,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire sbc_write_t wr_out,
    input wire sbc_flag_read_t flag_read,
    input wire logic frame_error,
    input wire logic parity_error,
    input wire logic cs_short
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_wr_pulse; wr_out.valid |=> !wr_out.valid; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_fr_pulse; flag_read.valid |=> !flag_read.valid; endproperty
    a_fr_pulse: assert property (p_fr_pulse) else $error("flag read pulse too long");
    property p_err_pulse; frame_error |=> !frame_error; endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("frame error too long");
    property p_par_nowr; parity_error |-> !wr_out.valid; endproperty
    a_par_nowr: assert property (p_par_nowr) else $error("write despite bad parity");
    property p_rd_wr; flag_read.valid |-> !wr_out.valid; endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("read and write together");
    property p_oe_idle; cs_n |-> miso_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("reply driven while deselected");
    property p_wr_after; wr_out.valid |-> $past(cs_n, 2); endproperty
    a_wr_after: assert property (p_wr_after) else $error("write before frame end");
    property p_rose_quiet; $rose(cs_n) |-> !wr_out.valid [*2]; endproperty
    a_rose_quiet: assert property (p_rose_quiet) else $error("write too early");
    property p_err_excl; !(frame_error && parity_error); endproperty
    a_err_excl: assert property (p_err_excl) else $error("two error kinds at once");

    c_write: cover property (wr_out.valid);
    c_flag: cover property (flag_read.valid);
    c_par: cover property (parity_error);
endmodule

bind sbc_spi_frame sbc_spi_frame_checker u_chk (.clk(clk), .rstn(rstn), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .parity_en(parity_en), .status_fixed(status_fixed),
    .status_ext(status_ext), .flag_set(flag_set), .miso(miso), .miso_oe_n(miso_oe_n),
    .wr_out(wr_out), .flag_read(flag_read), .frame_error(frame_error),
    .parity_error(parity_error), .cs_short(cs_short));

`default_nettype wire

// File: bench/sbc_spi_host.sv
// Host controller model acting as SPI master, mode 1
`timescale 1ns/100ps
`default_nettype none

module sbc_spi_host (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    // A late rise on select parks the link logic, whose flops have no reset
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
        #1;
        cs_n = 1'b1;
    end

    task automatic xfer(input logic [23:0] w, input int n, input int hold, output logic [23:0] r);
        r = '0;
        cs_n = 1'b0;
        #550;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            mosi = w[23-i];
            #7.5;
            sclk = 1'b0;
            r[23-i] = miso;
            #7.5;
        end
        #hold;
        cs_n = 1'b1;
        // Inverse on release so a stale bit cannot pass
        mosi = ~mosi;
        #600;
    endtask
endmodule

`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the SPI command frame block
`timescale 1ns/100ps
`default_nettype none

module testbench
    import sbc_spi_pkg::*;
;
    localparam int L = 5200;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic parity_en = 1'b0;
    logic [7:0] sf = 8'h00;
    logic [7:0] se = 8'h00;
    sbc_flag_set_t fs = '0;
    logic sclk, cs_n, mosi, miso, miso_oe_n, frame_error, parity_error, cs_short;
    sbc_write_t wr_out, wr_got;
    sbc_flag_read_t flag_read, fr_got;
    logic [7:0] mem [32] = '{default: 8'h00};
    logic [7:0] flg [32] = '{default: 8'h00};
    logic [4:0] seen = '0;
    logic [23:0] rx;
    logic [4:0] a;
    logic [7:0] d;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 8;
    int cyc = 0;

    always #20 clk = ~clk;

    sbc_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    sbc_spi_frame DUT (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .parity_en(parity_en), .status_fixed(sf), .status_ext(se), .flag_set(fs),
        .miso(miso), .miso_oe_n(miso_oe_n), .wr_out(wr_out), .flag_read(flag_read),
        .frame_error(frame_error), .parity_error(parity_error), .cs_short(cs_short));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        seen <= seen | {cs_short, parity_error, frame_error, flag_read.valid, wr_out.valid};
        if (wr_out.valid === 1'b1) wr_got <= wr_out;
        if (flag_read.valid === 1'b1) fr_got <= flag_read;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] rnd8();
        return 8'($random(seed));
    endfunction

    function automatic logic [15:0] exp_reply(input logic [1:0] c, input logic [4:0] ad);
        logic [7:0] lo;
        lo = se;
        if (c == 2'h0) lo = mem[ad];
        if (c == 2'h3) lo = flg[ad];
        return {sf, lo};
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One frame of n bits, then reply, event pulses and written value compared
    task automatic run(input int n, input logic [1:0] c, input logic [4:0] ad, input logic p,
                       input logic [7:0] dt, input int hold, input logic [4:0] ev);
        logic [23:0] ex;
        @(posedge clk);
        sf <= rnd8();
        se <= rnd8();
        @(posedge clk);
        @(posedge clk);
        // Select moves off the clock edge so the synchroniser sees no race
        #1;
        seen = '0;
        ex = {exp_reply(c, ad), 8'h00} & ~(24'hFFFFFF >> n);
        u_host.xfer({c, ad, p, dt, 8'h00}, n, hold, rx);
        check(rx, ex);
        check({19'h0, seen}, {19'h0, ev});
        if (ev[0]) check({11'h0, wr_got.addr, wr_got.data}, {11'h0, ad, dt});
        if (ev[1]) check({19'h0, fr_got.addr}, {19'h0, ad});
        if (ev[0]) mem[ad] = dt;
        if (ev[1]) flg[ad] = 8'h00;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                @(posedge clk);
                parity_en <= 1'b1;
            end
            a = 5'($random(seed));
            d = rnd8();
            run(16, 2'h1, a, (i >= 8) & (^{2'h1, a, d}), d, L, 5'h01);
            run(16, 2'h0, a, 1'b1, 8'h00, L, 5'h00);
        end
        $display("test write and read back done");
        run(16, 2'h1, 5'h10, 1'b1, 8'hC0, L, 5'h08);
        run(16, 2'h1, 5'h13, 1'b0, 8'hC0, L, 5'h01);
        run(16, 2'h0, 5'h10, 1'b1, 8'h00, L, 5'h00);
        run(16, 2'h0, 5'h13, 1'b1, 8'h00, L, 5'h00);
        run(16, 2'h2, 5'h13, 1'b0, 8'h3C, L, 5'h00);
        run(16, 2'h0, 5'h13, 1'b1, 8'h00, L, 5'h00);
        $display("test parity and reserved done");
        @(posedge clk);
        fs <= '{valid: 1'b1, addr: 5'h12, bits: 8'hA5};
        @(posedge clk);
        fs <= '0;
        flg[5'h12] = 8'hA5;
        run(16, 2'h3, 5'h12, 1'b0, 8'h00, L, 5'h04);
        run(16, 2'h3, 5'h12, 1'b1, 8'h00, L, 5'h02);
        run(16, 2'h3, 5'h12, 1'b1, 8'h00, L, 5'h02);
        $display("test flags done");
        run(24, 2'h0, 5'h13, 1'b1, 8'h00, L, 5'h04);
        run(8, 2'h1, 5'h13, 1'b0, 8'h77, L, 5'h04);
        run(16, 2'h0, 5'h13, 1'b1, 8'h00, 0, 5'h10);
        $display("test length and select time done");
        tally_and_finish();
    end
endmodule

`default_nettype wire

// File: logic/sbc_spi_frame.sv
// SPI command frame front end: link shifter, frame decode, register and flag store
// How it works
// RL1: one 16-bit frame, command in top bits
// RL2: bits 13 to 9 select register
// RL3: bit 8 parity on write, next on read
// RL4: low byte carries the write data
// RL5: status byte leads every reply
// RL6: writes answer with extended status byte
// RL7: reads answer with addressed register byte
// RL8: no daisy chain, frame ends here
// RL9: code 00 reads back control contents
// RL10: code 01 writes, bit 8 parity
// RL11: code 10 ignored, nothing changes
// RL12: code 11 reads flags, bit 8 one
// RL13: every register reads back its contents
// RL14: master holds select low over 5.5 us
// RL15: master follows writes with a read
// RL16: one read after a write series
// RL17: missed write completes at next frame
// RL18: only writes can be missed
`timescale 1ns/100ps
`default_nettype none
`include "sbc_spi_map.svh"

module sbc_spi_frame
    import sbc_spi_pkg::*;
#(
    parameter int REGS = `SBC_REG_COUNT,
    parameter bit DEFER_WRITE = 1'b0,
    parameter int CSLOW_CYC = `SBC_CSLOW_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic parity_en,
    input wire logic [7:0] status_fixed,
    input wire logic [7:0] status_ext,
    input wire sbc_flag_set_t flag_set,
    output logic miso,
    output logic miso_oe_n,
    output sbc_write_t wr_out,
    output sbc_flag_read_t flag_read,
    output logic frame_error,
    output logic parity_error,
    output logic cs_short
);

    sbc_state_t state;
    sbc_state_t next_state;
    logic cs_sync;
    logic parity_en_sync;
    logic [7:0] snap_fixed;
    logic [7:0] snap_ext;
    logic [7:0] rx_head;
    sbc_cmd_t rx_cmd;
    logic [4:0] rx_addr;
    logic [15:0] link_word;
    logic link_full;
    logic link_long;
    logic [7:0] reply_byte;
    sbc_frame_t cap;
    logic cap_ok;
    logic [7:0] cs_cnt;
    logic [7:0] ctrl_mem [REGS];
    logic [7:0] flag_mem [REGS];
    logic [7:0] pend_mem [REGS];
    sbc_write_t pend_wr;
    sbc_write_t commit;
    logic clear_flags;

    localparam logic [7:0] CSLOW_LIM = 8'(CSLOW_CYC);

    // Command code of a frame from its two top bits
    function automatic sbc_cmd_t sbc_cmd_of(input sbc_frame_t f);
        return sbc_cmd_t'({f.command_code_high, f.command_code_low});
    endfunction

    // Bit 8 against the parity setting: even over all sixteen bits
    function automatic logic sbc_parity_ok(input sbc_frame_t f, input logic en);
        logic others;
        others = ^{f.command_code_high, f.command_code_low, f.register_select_field, f.write_data_byte};
        if (en) begin
            return f.next_bit == others;
        end
        return f.next_bit == 1'b0;
    endfunction

    // A decodable frame of the given command is closing this cycle
    function automatic logic sbc_closing(input sbc_state_t st, input logic ok, input sbc_frame_t f, input sbc_cmd_t c);
        return st == SBC_ST_CLOSE && ok && sbc_cmd_of(f) == c;
    endfunction

    // Addresses past the store read as reset value instead of unknown
    function automatic logic sbc_reg_hit(input logic [4:0] ad);
        return int'(ad) < REGS;
    endfunction

    // Frame boundary seen in the system clock domain
    sbc_sync2 #(
        .WIDTH(1),
        .INIT(1'b1)
    ) u_cs_sync (
        .clk(clk),
        .rstn(rstn),
        .d(cs_n),
        .q(cs_sync)
    );

    // Parity setting is a strap from outside this clock; settle it first
    sbc_sync2 #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_par_sync (
        .clk(clk),
        .rstn(rstn),
        .d(parity_en),
        .q(parity_en_sync)
    );

    sbc_spi_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .fixed_status(snap_fixed),
        .reply_byte(reply_byte),
        .rx_head(rx_head),
        .frame_word(link_word),
        .frame_full(link_full),
        .frame_long(link_long),
        .miso(miso),
        .miso_oe_n(miso_oe_n)
    );

    // Frame tracker
    always_comb begin
        next_state = state;
        unique case (state)
            SBC_ST_IDLE: begin
                if (!cs_sync) begin
                    next_state = SBC_ST_ACTIVE;
                end
            end
            SBC_ST_ACTIVE: begin
                if (cs_sync) begin
                    next_state = SBC_ST_CLOSE;
                end
            end
            SBC_ST_CLOSE: begin
                next_state = SBC_ST_IDLE;
            end
            default: begin
                next_state = SBC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= SBC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Status is frozen while a frame runs, so the link sees a stable byte
    always_ff @(posedge clk) begin
        if (!rstn) begin
            snap_fixed <= `SBC_STATUS_RESET;
            snap_ext <= `SBC_STATUS_RESET;
        end else if (state == SBC_ST_IDLE && cs_sync) begin
            snap_fixed <= status_fixed;
            snap_ext <= status_ext;
        end
    end

    // RL14: select low time check
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cs_cnt <= 8'h00;
            cs_short <= 1'b0;
        end else begin
            cs_short <= 1'b0;
            if (state == SBC_ST_IDLE) begin
                cs_cnt <= 8'h00;
            end else if (state == SBC_ST_ACTIVE) begin
                if (cs_cnt != 8'hFF) begin
                    cs_cnt <= cs_cnt + 8'h01;
                end
                if (cs_sync && cs_cnt < CSLOW_LIM) begin
                    cs_short <= 1'b1;
                end
            end
        end
    end

    // Link words are quiet once select is high; take them as the frame closes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cap <= '0;
            cap_ok <= 1'b0;
        end else if (state == SBC_ST_ACTIVE && cs_sync) begin
            cap <= sbc_frame_t'(link_word);
            // RL1: exactly sixteen bits
            cap_ok <= link_full && !link_long;
        end
    end

    // Head of the incoming frame as the link holds it at the eighth bit
    assign rx_cmd = sbc_cmd_t'(rx_head[7:6]);
    assign rx_addr = rx_head[5:1];

    // RL7: reply low byte by address
    always_comb begin
        reply_byte = snap_ext;
        unique case (rx_cmd)
            // RL9: control read-back
            SBC_CMD_READ_CTRL: reply_byte = sbc_reg_hit(rx_addr) ? ctrl_mem[rx_addr] : `SBC_CTRL_RESET;
            // RL12: flag read
            SBC_CMD_READ_FLAGS: reply_byte = sbc_reg_hit(rx_addr) ? flag_mem[rx_addr] : `SBC_FLAG_RESET;
            // RL6: extended status
            SBC_CMD_WRITE: reply_byte = snap_ext;
            SBC_CMD_RESERVED: reply_byte = snap_ext;
        endcase
    end

    // Decode and check a closed frame
    always_ff @(posedge clk) begin
        if (!rstn) begin
            frame_error <= 1'b0;
            parity_error <= 1'b0;
            pend_wr <= '0;
            flag_read <= '0;
        end else begin
            frame_error <= 1'b0;
            parity_error <= 1'b0;
            flag_read <= '0;
            if (state == SBC_ST_ACTIVE && !cs_sync && DEFER_WRITE) begin
                pend_wr.valid <= 1'b0;
            end
            if (state == SBC_ST_CLOSE) begin
                if (!cap_ok) begin
                    frame_error <= 1'b1;
                end else begin
                    unique case (sbc_cmd_of(cap))
                        // RL10: write with parity
                        SBC_CMD_WRITE: begin
                            if (sbc_parity_ok(cap, parity_en_sync)) begin
                                // RL2: target address
                                pend_wr.addr <= cap.register_select_field;
                                // RL4: data byte
                                pend_wr.data <= cap.write_data_byte;
                                pend_wr.valid <= 1'b1;
                            end else begin
                                parity_error <= 1'b1;
                            end
                        end
                        // RL3: reads need next bit set
                        SBC_CMD_READ_CTRL: begin
                            if (!cap.next_bit) begin
                                frame_error <= 1'b1;
                            end
                        end
                        SBC_CMD_READ_FLAGS: begin
                            if (!cap.next_bit) begin
                                frame_error <= 1'b1;
                            end else begin
                                flag_read.valid <= 1'b1;
                                flag_read.addr <= cap.register_select_field;
                            end
                        end
                        // RL11: reserved code dropped
                        SBC_CMD_RESERVED: begin
                            frame_error <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // RL17: deferred write completion
    always_comb begin
        commit = '0;
        if (DEFER_WRITE) begin
            if (state == SBC_ST_IDLE && !cs_sync) begin
                commit = pend_wr;
            end
        end else if (sbc_closing(state, cap_ok, cap, SBC_CMD_WRITE)) begin
            commit.valid = sbc_parity_ok(cap, parity_en_sync);
            commit.addr = cap.register_select_field;
            commit.data = cap.write_data_byte;
        end
    end

    // RL18: only writes take the deferred path
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_out <= '0;
        end else begin
            wr_out <= commit;
        end
    end

    // RL13: stored contents for read-back
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < REGS; i++) begin
                ctrl_mem[i] <= `SBC_CTRL_RESET;
            end
        end else if (commit.valid) begin
            ctrl_mem[commit.addr] <= commit.data;
        end
    end

    assign clear_flags = sbc_closing(state, cap_ok, cap, SBC_CMD_READ_FLAGS) && cap.next_bit;

    // Flags set while a frame runs wait in a pending copy; the link reads a
    // stable store, and a set in the clearing cycle survives the clear
    for (genvar g = 0; g < REGS; g++) begin : g_flag
        logic [7:0] set_bits;
        logic [7:0] clr_bits;

        assign set_bits = (flag_set.valid && flag_set.addr == 5'(g)) ? flag_set.bits : 8'h00;
        assign clr_bits = (clear_flags && cap.register_select_field == 5'(g)) ? 8'hFF : 8'h00;

        always_ff @(posedge clk) begin
            if (!rstn) begin
                flag_mem[g] <= `SBC_FLAG_RESET;
                pend_mem[g] <= 8'h00;
            end else if (state == SBC_ST_ACTIVE) begin
                pend_mem[g] <= pend_mem[g] | set_bits;
            end else begin
                // RL12: read clears, set wins
                flag_mem[g] <= (flag_mem[g] & ~clr_bits) | pend_mem[g] | set_bits;
                pend_mem[g] <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

// File: logic/sbc_spi_link.sv
// Shift logic on the SPI clock: samples on falling, launches on rising edge
`timescale 1ns/100ps
`default_nettype none
`include "sbc_spi_map.svh"

module sbc_spi_link
    import sbc_spi_pkg::*;
(
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [7:0] fixed_status,
    input wire logic [7:0] reply_byte,
    output logic [7:0] rx_head,
    output logic [15:0] frame_word,
    output logic frame_full,
    output logic frame_long,
    output logic miso,
    output logic miso_oe_n
);
    logic [4:0] cnt;
    logic [15:0] shift;
    logic [7:0] tx_low;

    // Chip select high parks the counter; the link clock stands still then
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 5'h00;
        end else if (cnt != `SBC_CNT_LONG) begin
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(negedge sclk) begin
        shift <= {shift[14:0], mosi};
    end

    // RL1: length check
    always_ff @(negedge sclk) begin
        if (cnt == 5'h00) begin
            frame_full <= 1'b0;
            frame_long <= 1'b0;
        end
        if (cnt == `SBC_CNT_LAST) begin
            frame_word <= {shift[14:0], mosi};
            frame_full <= 1'b1;
        end
        if (cnt > `SBC_CNT_LAST) begin
            frame_long <= 1'b1;
        end
    end

    assign rx_head = shift[7:0];

    // RL5: status byte first
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
            tx_low <= 8'h00;
        end else begin
            miso_oe_n <= 1'b0;
            if (cnt < `SBC_CNT_LOW) begin
                miso <= fixed_status[~cnt[2:0]];
            end else if (cnt == `SBC_CNT_LOW) begin
                miso <= reply_byte[7];
                tx_low <= reply_byte;
            end else if (cnt <= `SBC_CNT_LAST) begin
                miso <= tx_low[~cnt[2:0]];
            end else begin
                // RL8: no pass-through
                miso <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// File: logic/sbc_spi_map.svh
// Offsets, field positions, reset values and timing counts of the SPI command frame
`ifndef SBC_SPI_MAP_SVH
`define SBC_SPI_MAP_SVH

`define SBC_FRAME_BITS 16
`define SBC_CMD_MSB 15
`define SBC_CMD_LSB 14
`define SBC_ADDR_MSB 13
`define SBC_ADDR_LSB 9
`define SBC_PN_BIT 8
`define SBC_DATA_MSB 7
`define SBC_DATA_LSB 0
`define SBC_REG_COUNT 32
`define SBC_CTRL_RESET 8'h00
`define SBC_FLAG_RESET 8'h00
`define SBC_STATUS_RESET 8'h00
`define SBC_CNT_LONG 5'h11
`define SBC_CNT_LAST 5'h0F
`define SBC_CNT_LOW 5'h08
`define SBC_CLK_MHZ 25
`define SBC_T_CSLOW_NS 5500
`define SBC_CSLOW_CYC ((`SBC_T_CSLOW_NS * `SBC_CLK_MHZ + 999) / 1000)

`endif

// File: logic/sbc_spi_pkg.sv
// Types shared by the SPI command frame logic
package sbc_spi_pkg;

    typedef enum logic [1:0] {
        SBC_CMD_READ_CTRL = 2'h0,
        SBC_CMD_WRITE = 2'h1,
        SBC_CMD_RESERVED = 2'h2,
        SBC_CMD_READ_FLAGS = 2'h3
    } sbc_cmd_t;

    typedef enum logic [1:0] {
        SBC_ST_IDLE = 2'h0,
        SBC_ST_ACTIVE = 2'h1,
        SBC_ST_CLOSE = 2'h3
    } sbc_state_t;

    typedef struct packed {
        logic command_code_high;
        logic command_code_low;
        logic [4:0] register_select_field;
        logic next_bit;
        logic [7:0] write_data_byte;
    } sbc_frame_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [7:0] data;
    } sbc_write_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [7:0] bits;
    } sbc_flag_set_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
    } sbc_flag_read_t;

endpackage

// File: logic/sbc_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none

module sbc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

`default_nettype wire
